// ---- rtl/twb_params.svh ----
// Offsets, field positions, reset values and timing counts of the two-wire bus engine.
// Assumes a byte-addressed APB slave with 32-bit data.
`ifndef TWB_PARAMS_SVH
`define TWB_PARAMS_SVH
`define OFF_CTRL      8'h00
`define OFF_STAT      8'h04
`define OFF_DATA      8'h08
`define OFF_PER       8'h0c
`define OFF_ADDR      8'h10
`define CTRL_EN       0
`define CTRL_MST      1
`define CTRL_TRS      2
`define CTRL_REXT     3
`define CTRL_ACK      4
`define CTRL_START    5
`define CTRL_STOP     6
`define PER_RST       9'h100
`define ADDR_RST      7'h00
`define SCLO_MIN      9'h01c
`define SCLO_MAX      9'h100
`define MST_DLY       9'h003
`define STO_EXTRA     9'h002
`define BUF_LESS      9'h001
`define RISE_ALLOW0   9'h008
`define RISE_ALLOW1   9'h012
`define SYNC_LAT      9'h003
`define SLV_SETUP0    4'h6
`define SLV_SETUP1    4'hc
`define SLV_LAT       4'h4
`define CLK_MHZ       250
`define MIN_CLK_MHZ   5
`endif

// ---- rtl/twb_pkg.sv ----
// Types of the two-wire bus engine: sequencer states and the packed state records.
// Assumes the constants of twb_params.svh are included where numbers are needed.
package twb_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_STA_HOLD, ST_WAIT, ST_LOW, ST_HIGH,
        ST_RS_LOW, ST_RS_HIGH, ST_STO_LOW, ST_STO_HIGH, ST_BUF
    } seq_t;

    typedef struct packed {
        seq_t        st;
        logic [8:0]  cnt;
        logic        en;
        logic        mst;
        logic        transmit_direction_bit;
        logic        rext;
        logic        ack_out;
        logic        start_req;
        logic        stop_req;
        logic [8:0]  per;
        logic [6:0]  own;
        logic [7:0]  txh;
        logic [7:0]  rxh;
        logic [7:0]  sh;
        logic        tx_full;
        logic        rx_full;
        logic        rx_go;
        logic        rx_pend;
        logic [3:0]  bitn;
        logic        ack_in;
        logic        bus_occupied_flag;
        logic        scl_oe;
        logic        sda_oe;
        logic        scl_p;
        logic        sda_p;
        logic        sl_act;
        logic        sl_sel;
        logic        sl_tx;
        logic        sl_addr;
        logic        sl_pend;
        logic        sl_nxt;
        logic [3:0]  sl_dly;
        logic [31:0] prdata;
    } core_state_t;

    typedef struct packed {
        logic [1:0] s0;
        logic [1:0] l1;
        logic [1:0] l2;
        logic [1:0] clean;
    } filt_state_t;
endpackage

// ---- rtl/bus_lines_if.sv ----
// Carrier between the core and its input filter: raw and filtered line levels.
// Bit 1 is SCL and bit 0 is SDA in both vectors.
`timescale 1ns/1ps
interface bus_lines_if;
    logic [1:0] raw;
    logic [1:0] clean;
    modport filt (input raw, output clean);
    modport core (output raw, input clean);
endinterface

// ---- rtl/noise_filter.sv ----
// Synchroniser and agreement filter for the SCL and SDA inputs.
// Assumes raw levels arrive asynchronously from the pads.
`timescale 1ns/1ps
module noise_filter (
    input  wire logic pclk,
    input  wire logic presetn,
    bus_lines_if.filt lines
);
    twb_pkg::filt_state_t q;
    twb_pkg::filt_state_t d;

    // The first stage only feeds the second, so metastability never reaches the comparator.
    always_comb begin
        d = q;
        d.s0 = lines.raw;
        d.l1 = q.s0;
        d.l2 = q.l1;
        d.clean = (q.l1 & ~(q.l1 ^ q.l2)) | (q.clean & (q.l1 ^ q.l2));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign lines.clean = q.clean;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_FILT_AGREE: assert property (((q.clean ^ $past(q.clean)) & ($past(q.l1) ^ $past(q.l2))) == 2'h0)
        else $error("Filtered line changed while the latches disagreed.");
endmodule

// ---- rtl/twb_core.sv ----
// Two-wire bus engine, master or slave, with its registers on APB.
// Assumes open-drain pads with pull-ups outside; all timing counts are pclk cycles.
`timescale 1ns/1ps
`include "twb_params.svh"
// Notes on behaviour
// - Start then instant stop gives no promised waveform.
// - Busy flag may set before SCL low.
// - Data write with transmit starts next transfer.
// - Data read with receive starts next transfer.
// - SCL period selectable from 28 to 256.
// - High and low phases each half period.
// - Bus free and start hold: half minus one.
// - Repeated start setup is one full period.
// - Stop setup is half period plus two.
// - Master data valid three cycles after fall.
// - Slave setup is low minus 6 or 12.
// - SDA held three cycles after SCL falls.
// - Inputs sampled on pclk; needs 5 MHz.
// - Master waits for SCL high every bit.
// - Rise allowance 7.5 or 17.5 cycles.
// - Two latches must agree before forwarding.
// - Clearing enable initialises sequencer and pins.
module twb_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);
    twb_pkg::core_state_t q;
    twb_pkg::core_state_t d;
    bus_lines_if          lines ();
    logic                 scl_in;
    logic                 sda_in;
    logic                 rd_acc;
    logic                 wr_acc;
    logic                 mapped;
    logic                 stall;
    logic                 scl_rise;
    logic                 scl_fall;
    logic                 start_det;
    logic                 stop_det;
    logic [8:0]           half;
    logic [8:0]           hm1;
    logic [8:0]           allow;
    logic [8:0]           per_w;

    assign lines.raw = {scl_i, sda_i};

    // Both lines are synchronised to pclk; at 250 MHz the 5 MHz floor is far away.
    noise_filter noise_filter_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .lines   (lines)
    );

    assign scl_in    = lines.clean[1];
    assign sda_in    = lines.clean[0];
    assign scl_rise  = scl_in & ~q.scl_p;
    assign scl_fall  = ~scl_in & q.scl_p;
    assign start_det = scl_in & q.scl_p & q.sda_p & ~sda_in;
    assign stop_det  = scl_in & q.scl_p & ~q.sda_p & sda_in;
    assign rd_acc    = psel & penable & ~pwrite;
    assign wr_acc    = psel & penable & pwrite;
    assign mapped    = (paddr == `OFF_CTRL) | (paddr == `OFF_STAT) | (paddr == `OFF_DATA) |
                       (paddr == `OFF_PER) | (paddr == `OFF_ADDR);
    assign pready    = 1'h1;
    assign pslverr   = psel & penable & ~mapped;
    assign half      = {1'h0, q.per[8:1]};
    assign hm1       = half - 9'h001;
    assign allow     = (q.rext ? `RISE_ALLOW1 : `RISE_ALLOW0) + `SYNC_LAT;
    assign stall     = ~scl_in & ((q.cnt >= allow) | (q.cnt >= hm1));
    assign per_w     = (pwdata[31:9] != 23'h0 || pwdata[8:0] > `SCLO_MAX) ? `SCLO_MAX :
                       (pwdata[8:0] < `SCLO_MIN) ? `SCLO_MIN : pwdata[8:0];

    always_comb begin
        d = q;
        d.scl_p = scl_in;
        d.sda_p = sda_in;
        // The flag follows the bus lines, so it can rise before our own SCL has fallen.
        if (start_det) begin
            d.bus_occupied_flag = 1'h1;
        end else if (stop_det) begin
            d.bus_occupied_flag = 1'h0;
        end
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFF_CTRL: d.prdata = {27'h0, q.ack_out, q.rext, q.transmit_direction_bit, q.mst, q.en};
                `OFF_STAT: d.prdata = {24'h0, q.sl_sel, q.st == twb_pkg::ST_WAIT, sda_in, scl_in,
                                       q.ack_in, q.rx_full, q.tx_full, q.bus_occupied_flag};
                `OFF_DATA: d.prdata = {24'h0, q.rxh};
                `OFF_PER:  d.prdata = {23'h0, q.per};
                `OFF_ADDR: d.prdata = {25'h0, q.own};
                default:   d.prdata = 32'h0;
            endcase
        end
        if (rd_acc && paddr == `OFF_DATA && q.en && !q.transmit_direction_bit) begin
            d.rx_full = 1'h0;
            d.rx_go = 1'h1;
            if (q.rx_pend) begin
                d.rxh = q.sh;
                d.rx_full = 1'h1;
                d.rx_pend = 1'h0;
            end
        end
        if (q.en && q.mst) begin
            case (q.st)
                twb_pkg::ST_IDLE: begin
                    d.cnt = 9'h000;
                    if (q.start_req && !q.bus_occupied_flag) begin
                        d.start_req = 1'h0;
                        d.sda_oe = 1'h1;
                        d.st = twb_pkg::ST_STA_HOLD;
                    end else begin
                        d.stop_req = 1'h0;
                    end
                end
                twb_pkg::ST_STA_HOLD: begin
                    d.cnt = q.cnt + 9'h001;
                    if (q.cnt == hm1 - 9'h001) begin
                        d.scl_oe = 1'h1;
                        d.cnt = 9'h000;
                        d.st = twb_pkg::ST_WAIT;
                    end
                end
                twb_pkg::ST_WAIT: begin
                    d.cnt = 9'h000;
                    // A stop queued behind a start is only served once SCL is held low.
                    if (q.stop_req) begin
                        d.stop_req = 1'h0;
                        d.st = twb_pkg::ST_STO_LOW;
                    end else if (q.start_req) begin
                        d.start_req = 1'h0;
                        d.st = twb_pkg::ST_RS_LOW;
                    end else if (q.transmit_direction_bit && q.tx_full) begin
                        d.sh = q.txh;
                        d.tx_full = 1'h0;
                        d.bitn = 4'h0;
                        d.st = twb_pkg::ST_LOW;
                    end else if (!q.transmit_direction_bit && d.rx_go && !d.rx_pend) begin
                        d.rx_go = 1'h0;
                        d.bitn = 4'h0;
                        d.st = twb_pkg::ST_LOW;
                    end
                end
                twb_pkg::ST_LOW: begin
                    d.cnt = q.cnt + 9'h001;
                    if (q.cnt == `MST_DLY - 9'h001) begin
                        d.sda_oe = (q.bitn < 4'h8) ? (q.transmit_direction_bit & ~q.sh[7]) : (~q.transmit_direction_bit & ~q.ack_out);
                    end
                    if (q.cnt == hm1) begin
                        d.scl_oe = 1'h0;
                        d.cnt = 9'h000;
                        d.st = twb_pkg::ST_HIGH;
                    end
                end
                twb_pkg::ST_HIGH: begin
                    if (!stall) begin
                        d.cnt = q.cnt + 9'h001;
                    end
                    if (scl_in && q.cnt >= hm1) begin
                        d.scl_oe = 1'h1;
                        d.cnt = 9'h000;
                        d.bitn = q.bitn + 4'h1;
                        d.st = twb_pkg::ST_LOW;
                        if (q.bitn == 4'h8) begin
                            d.bitn = 4'h0;
                            d.ack_in = sda_in;
                            d.st = twb_pkg::ST_WAIT;
                            if (!q.transmit_direction_bit) begin
                                if (!d.rx_full) begin
                                    d.rxh = q.sh;
                                    d.rx_full = 1'h1;
                                    d.rx_go = 1'h1;
                                end else begin
                                    d.rx_pend = 1'h1;
                                end
                            end
                        end else begin
                            d.sh = {q.sh[6:0], sda_in};
                        end
                    end
                end
                twb_pkg::ST_RS_LOW, twb_pkg::ST_STO_LOW: begin
                    d.cnt = q.cnt + 9'h001;
                    if (q.cnt == `MST_DLY - 9'h001) begin
                        d.sda_oe = (q.st == twb_pkg::ST_STO_LOW);
                    end
                    if (q.cnt == hm1) begin
                        d.scl_oe = 1'h0;
                        d.cnt = 9'h000;
                        d.st = (q.st == twb_pkg::ST_RS_LOW) ? twb_pkg::ST_RS_HIGH : twb_pkg::ST_STO_HIGH;
                    end
                end
                twb_pkg::ST_RS_HIGH: begin
                    if (scl_in) begin
                        d.cnt = q.cnt + 9'h001;
                    end
                    if (scl_in && q.cnt == q.per - 9'h001) begin
                        d.sda_oe = 1'h1;
                        d.cnt = 9'h000;
                        d.st = twb_pkg::ST_STA_HOLD;
                    end
                end
                twb_pkg::ST_STO_HIGH: begin
                    if (scl_in) begin
                        d.cnt = q.cnt + 9'h001;
                    end
                    if (scl_in && q.cnt == half + `STO_EXTRA - 9'h001) begin
                        d.sda_oe = 1'h0;
                        d.cnt = 9'h000;
                        d.st = twb_pkg::ST_BUF;
                    end
                end
                twb_pkg::ST_BUF: begin
                    d.cnt = q.cnt + 9'h001;
                    // Bus free is short of the bus standard; software spaces stop and start.
                    if (q.cnt == hm1 - `BUF_LESS) begin
                        d.cnt = 9'h000;
                        d.st = twb_pkg::ST_IDLE;
                    end
                end
                default: d.st = twb_pkg::ST_IDLE;
            endcase
        end
        if (q.en && !q.mst) begin
            if (start_det) begin
                d.sl_act = 1'h1;
                d.sl_sel = 1'h0;
                d.sl_addr = 1'h1;
                d.sl_pend = 1'h0;
                d.bitn = 4'h0;
                d.sda_oe = 1'h0;
            end else if (stop_det) begin
                d.sl_act = 1'h0;
                d.sl_sel = 1'h0;
                d.sl_pend = 1'h0;
                d.sda_oe = 1'h0;
            end else if (q.sl_act && scl_rise) begin
                if (q.bitn < 4'h8) begin
                    d.sh = {q.sh[6:0], sda_in};
                end else begin
                    d.ack_in = sda_in;
                end
            end else if (q.sl_act && scl_fall) begin
                d.sl_pend = 1'h1;
                d.sl_dly = (q.rext ? `SLV_SETUP1 : `SLV_SETUP0) - `SLV_LAT;
                d.bitn = q.bitn + 4'h1;
                d.sl_nxt = q.sl_sel & q.sl_tx & ~q.sl_addr & ~q.sh[7];
                if (q.bitn == 4'h7) begin
                    d.sl_nxt = 1'h0;
                    if (q.sl_addr) begin
                        d.sl_addr = 1'h0;
                        d.sl_sel = (q.sh[7:1] == q.own);
                        d.sl_tx = q.sh[0];
                        d.sl_nxt = (q.sh[7:1] == q.own);
                    end else if (q.sl_sel && !q.sl_tx) begin
                        d.rxh = q.sh;
                        d.rx_full = 1'h1;
                        d.sl_nxt = ~q.ack_out;
                    end
                end else if (q.bitn == 4'h8) begin
                    d.bitn = 4'h0;
                    d.sl_nxt = 1'h0;
                    if (q.sl_sel && q.sl_tx) begin
                        d.sh = q.txh;
                        d.tx_full = 1'h0;
                        d.sl_nxt = ~q.txh[7];
                    end
                end
            end
            if (q.sl_pend) begin
                d.sl_dly = q.sl_dly - 4'h1;
                if (q.sl_dly == 4'h0) begin
                    d.sl_pend = 1'h0;
                    d.sda_oe = q.sl_nxt;
                end
            end
        end
        // Register contents survive; only the transfer machinery is put back to rest.
        if (!q.en) begin
            d.st = twb_pkg::ST_IDLE;
            d.cnt = 9'h000;
            d.scl_oe = 1'h0;
            d.sda_oe = 1'h0;
            d.tx_full = 1'h0;
            d.rx_full = 1'h0;
            d.rx_go = 1'h0;
            d.rx_pend = 1'h0;
            d.bitn = 4'h0;
            d.start_req = 1'h0;
            d.stop_req = 1'h0;
            d.sl_act = 1'h0;
            d.sl_sel = 1'h0;
            d.sl_pend = 1'h0;
        end
        if (wr_acc) begin
            case (paddr)
                `OFF_CTRL: begin
                    d.en = pwdata[`CTRL_EN];
                    d.mst = pwdata[`CTRL_MST];
                    d.transmit_direction_bit = pwdata[`CTRL_TRS];
                    d.rext = pwdata[`CTRL_REXT];
                    d.ack_out = pwdata[`CTRL_ACK];
                    d.start_req = d.start_req | pwdata[`CTRL_START];
                    d.stop_req = d.stop_req | pwdata[`CTRL_STOP];
                end
                `OFF_DATA: begin
                    d.txh = pwdata[7:0];
                    d.tx_full = d.tx_full | (q.en & q.transmit_direction_bit);
                end
                `OFF_PER:  d.per = per_w;
                `OFF_ADDR: d.own = pwdata[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.per <= `PER_RST;
            q.own <= `ADDR_RST;
            q.scl_p <= 1'h1;
            q.sda_p <= 1'h1;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign scl_o  = 1'h0;
    assign sda_o  = 1'h0;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PER_RANGE: assert property (q.per >= `SCLO_MIN && q.per <= `SCLO_MAX)
        else $error("SCL period left its range.");
    AST_LOW_END: assert property (q.en && q.mst && q.st == twb_pkg::ST_LOW && q.cnt == hm1 |=> !q.scl_oe)
        else $error("SCL low phase did not end after half a period.");
    AST_STA_HOLD: assert property ($rose(q.sda_oe) && q.st == twb_pkg::ST_STA_HOLD
                                  |-> !q.scl_oe throughout (q.st == twb_pkg::ST_STA_HOLD)[*3])
        else $error("SCL pulled low too early after start.");
    AST_SDA_HOLD: assert property ($rose(q.scl_oe) && q.mst |-> $stable(q.sda_oe) [*3])
        else $error("SDA changed within three cycles of SCL falling.");
    AST_SDA_VALID: assert property (q.en && q.mst && q.st == twb_pkg::ST_LOW && q.cnt == 9'h002 && q.bitn < 4'h8
                                   |=> q.sda_oe == ($past(q.transmit_direction_bit) & ~$past(q.sh[7])))
        else $error("Master data bit not presented three cycles into the low phase.");
    AST_STRETCH: assert property (q.en && q.mst && q.st == twb_pkg::ST_HIGH && stall
                                 |=> q.st == twb_pkg::ST_HIGH && q.cnt == $past(q.cnt))
        else $error("High phase ran on while SCL was not seen high.");
    AST_STOP_SETUP: assert property (q.en && q.mst && q.st == twb_pkg::ST_STO_HIGH && q.cnt < half + 9'h001
                                    |=> q.sda_oe)
        else $error("SDA released before stop setup elapsed.");
    AST_RS_SETUP: assert property (q.en && q.mst && q.st == twb_pkg::ST_RS_HIGH && q.cnt < q.per - 9'h001
                                  |=> !q.sda_oe)
        else $error("Repeated start driven before one full period.");
    AST_TX_TRIG: assert property (wr_acc && paddr == `OFF_DATA && q.en && q.transmit_direction_bit |=> q.tx_full)
        else $error("Data write did not arm the next transfer.");
    AST_RX_TRIG: assert property (rd_acc && paddr == `OFF_DATA && q.en && !q.transmit_direction_bit
                                 |=> q.rx_go || q.rx_full || q.st == twb_pkg::ST_LOW)
        else $error("Data read did not arm the next transfer.");
    AST_BUSY_CLR: assert property (stop_det && !start_det |=> !q.bus_occupied_flag)
        else $error("Busy flag stayed set after a stop.");
    AST_DISABLE: assert property ($fell(q.en) |=> q.st == twb_pkg::ST_IDLE && !q.scl_oe && !q.sda_oe)
        else $error("Disable did not initialise the sequencer.");

    COV_BYTE: cover property (q.st == twb_pkg::ST_HIGH ##1 q.st == twb_pkg::ST_WAIT);
    COV_RSTART: cover property (q.st == twb_pkg::ST_RS_HIGH ##1 q.st == twb_pkg::ST_STA_HOLD);
    COV_STOP: cover property (q.st == twb_pkg::ST_BUF ##1 q.st == twb_pkg::ST_IDLE);
    COV_SLAVE: cover property (!q.sl_sel ##1 q.sl_sel);
endmodule

// ---- testbench/twb_peer.sv ----
// Peer slave on the two-wire bus that acknowledges every byte it sees.
// Assumes pulled-up lines; it pulls SDA low only during the ninth bit of a byte.
`timescale 1ns/1ps
module twb_peer (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_pull
);
    int n = 0;
    initial sda_pull = 1'b0;
    // A start condition restarts the bit count.
    always @(negedge sda) if (scl) n = 0;
    always @(posedge scl) n = n + 1;
    // Changing right at the falling edge is the harshest hold a real slave may give.
    always @(negedge scl) begin
        if (n == 9) n = 0;
        sda_pull = (n == 8);
    end
endmodule

// ---- testbench/i2c_bus_timing_and_transfer_trigger_tb.sv ----
// Self-checking bench for the two-wire bus engine driven over APB.
// Assumes pull-ups on both lines and the peer slave model on the far side.
`timescale 1ns/1ps
`include "twb_params.svh"
module i2c_bus_timing_and_transfer_trigger_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pe, chk_on;
    logic [7:0]  paddr, b, rx;
    logic [31:0] pwdata, prdata, rd;
    logic        scl_o, sda_o, scl_oe, sda_oe, pull, scl, sda, ps, pd, pl;
    int          errors = 0, n_tests = 0, seed = 32'h135a, per, lo, hi, sh, fr, nb, v;
    int          tbl[5] = '{5, 27, 28, 256, 511};
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;
    twb_core twb_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe));
    twb_peer twb_peer_inst (.scl(scl), .sda(sda), .sda_pull(pull));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Entered just after an edge; one idle edge at the end keeps releases and setups apart.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        pe = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic waitstat(input int i, input logic x);
        apb(1'b0, `OFF_STAT, 32'h0);
        for (int k = 0; k < 400 && rd[i] !== x; k++) apb(1'b0, `OFF_STAT, 32'h0);
        chk({31'h0, rd[i]}, {31'h0, x});
    endtask
    task automatic waitnb(input int n);
        for (int k = 0; k < 3000 && nb != n; k++) @(posedge pclk);
    endtask
    function automatic int clamp(input int x);
        return (x < 28) ? 28 : ((x > 256) ? 256 : x);
    endfunction
    // Wire monitor: phase lengths are counted in pclk edges from the output enables, bus free from the SCL and SDA lines.
    always @(posedge pclk) begin
        if (chk_on && ps && !scl_oe && nb >= 1 && nb <= 8) chk(lo, per / 2);
        if (chk_on && !ps && scl_oe && nb >= 1 && nb <= 8) chk(hi, per / 2);
        if (chk_on && !ps && scl_oe && nb == 0 && sh > 0) chk(sh, per / 2 - 1);
        if (chk_on && pd != sda_oe && ps && scl_oe && nb >= 1 && nb <= 8) chk(lo >= 3 && lo <= 4, 1);
        if (chk_on && pd && !sda_oe && !ps && !scl_oe) chk(sh >= per / 2 + 2 && sh <= per / 2 + 6, 1);
        if (chk_on && pl && !sda && scl) chk(fr >= per / 2 - 1, 1);
        lo <= scl_oe ? lo + 1 : 0;
        hi <= scl_oe ? 0 : hi + 1;
        sh <= (sda_oe && !scl_oe) ? sh + 1 : 0;
        fr <= (scl && sda) ? fr + 1 : 0;
        if (ps && !scl_oe) nb <= nb + 1;
        if (ps && !scl_oe && nb < 8) rx <= {rx[6:0], sda};
        if (!ps && scl_oe && nb == 9) nb <= 0;
        if (pl && !sda && scl) nb <= 0;
        ps <= scl_oe;
        pd <= sda_oe;
        pl <= sda;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        test_done;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, chk_on, ps, pd, rx} = '0;
        {per, nb, lo, hi, sh, fr} = '0;
        pl = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `OFF_PER, 32'h0);
        chk(rd, 32'h100);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, pe}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            v = (k < 5) ? tbl[k] : ($random(seed) & 32'h1ff);
            apb(1'b1, `OFF_PER, v);
            apb(1'b0, `OFF_PER, 32'h0);
            chk(rd, clamp(v));
        end
        per = 28 + 2 * ($unsigned($random(seed)) % 20);
        apb(1'b1, `OFF_PER, per);
        chk_on = 1'b1;
        apb(1'b1, `OFF_CTRL, 32'h07);
        apb(1'b1, `OFF_CTRL, 32'h27);
        waitstat(6, 1'b1);
        repeat (2) begin
            b = $random(seed);
            apb(1'b1, `OFF_DATA, {24'h0, b});
            waitnb(9);
            waitstat(6, 1'b1);
            chk({24'h0, rx}, {24'h0, b});
        end
        apb(1'b1, `OFF_CTRL, 32'h47);
        waitstat(0, 1'b0);
        // A start right behind the stop exercises the shortest bus-free time.
        apb(1'b1, `OFF_CTRL, 32'h27);
        waitstat(6, 1'b1);
        waitstat(4, 1'b0);
        waitstat(5, 1'b0);
        apb(1'b1, `OFF_CTRL, 32'h47);
        waitstat(0, 1'b0);
        repeat (250) @(posedge pclk);
        apb(1'b1, `OFF_CTRL, 32'h23);
        waitstat(6, 1'b1);
        apb(1'b0, `OFF_DATA, 32'h0);
        waitstat(2, 1'b1);
        apb(1'b0, `OFF_DATA, 32'h0);
        chk(rd, 32'hff);
        apb(1'b1, `OFF_CTRL, 32'h27);
        waitstat(6, 1'b1);
        apb(1'b1, `OFF_DATA, $random(seed) & 32'hff);
        waitnb(4);
        chk_on = 1'b0;
        apb(1'b1, `OFF_CTRL, 32'h0);
        @(posedge pclk);
        chk({30'h0, scl_oe, sda_oe}, 32'h0);
        test_done;
    end
endmodule
